//--- dchp_drive_model.sv
// Drive-side model: takes positioning commands, reports seek end
`timescale 1ns/100ps
module dchp_drive_model #(
   parameter int TAKE_DLY = 6,
   parameter int SEEK_DLY = 10
) (
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       posLaunch,
   input  wire logic [1:0] posDrive,
   output logic            driveOrderTaken,
   output logic [3:0]      driveSeekEndPin,
   output logic [3:0]      driveReadyPin,
   output logic [3:0]      driveReservedPin
);
   int         cnt;
   logic [1:0] drv;
   // Drive 0 not ready, drive 1 reserved: recal must pick drive 2
   assign driveReadyPin    = 4'hE;
   assign driveReservedPin = 4'h2;
   always @(posedge sys_clk) begin
      driveOrderTaken <= !sys_rst && cnt == TAKE_DLY;
      if (sys_rst) begin
         cnt <= 0;
         driveSeekEndPin <= 4'h0;
      end else if (posLaunch) begin
         cnt <= 1;
         drv <= posDrive;
         driveSeekEndPin <= 4'h0;
      end else if (cnt > 0 && cnt < TAKE_DLY + SEEK_DLY) begin
         cnt <= cnt + 1;
      end else if (cnt != 0) begin
         driveSeekEndPin[drv] <= 1'b1;
         cnt <= 0;
      end
   end
endmodule

//--- dchp_host_io_port.sv
// Host I/O instruction port of the disk controller
`timescale 1ns/100ps
module dchp_host_io_port #(
   parameter bit         SURF_SIX = 1'b0,
   parameter logic [5:0] MAX_SURF = 6'h04,
   parameter logic [4:0] MAX_SECT = 5'h17,
   parameter longint     TMO_CYCLES = dchp_pkg::TMO_CYC
) (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic                   ce,
   input  wire dchp_pkg::dchp_host_req_s hostReq,
   input  wire logic [15:0]            hostDataOut,
   output logic      [15:0]            hostDataIn,
   output logic                        busy,
   output logic                        done,
   output logic                        ctrlFull,
   input  wire logic                   retryEnable,
   input  wire logic                   sectorEnd,
   input  wire logic                   eccMismatch,
   input  wire logic                   badSectorMark,
   output dchp_pkg::dchp_xfer_ctl_s    xferCtl,
   output logic      [5:0]             surfaceAddr,
   output logic      [4:0]             sectorAddr,
   output logic      [4:0]             sectorCount,
   output logic      [3:0]             opcode,
   output logic      [1:0]             driveSel,
   output logic                        posLaunch,
   output logic      [3:0]             posOpcode,
   output logic      [1:0]             posDrive,
   input  wire logic                   driveOrderTaken,
   input  wire logic [3:0]             driveSeekEndPin,
   input  wire logic [3:0]             driveReadyPin,
   input  wire logic [3:0]             driveReservedPin,
   input  wire logic                   driveErrorPin,
   output logic                        attnIntDisable,
   output logic                        memAddrZero,
   output logic                        altModesOff
);

   // ****************************************************
   // Elaboration checks
   // ****************************************************
   initial begin
      if (MAX_SURF == 6'h00 || MAX_SECT == 5'h00)
         $error("dchp_host_io_port: capacity must be nonzero");
   end

   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   logic [3:0] seekEndS, readyS, reservedS;
   logic       driveErrS;
   logic [3:0] seekEndPrev_r;

   dchp_sync #(.WIDTH(13)) uSync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .asyncIn ({driveSeekEndPin, driveReadyPin, driveReservedPin, driveErrorPin}),
      .syncOut ({seekEndS, readyS, reservedS, driveErrS})
   );

   // Edge taken after the second stage, never on the first
   wire [3:0] seekEndRise = seekEndS & ~seekEndPrev_r;

   // ****************************************************
   // Decode
   // ****************************************************
   function automatic logic [1:0] lowestFree(input logic [3:0] ok);
      lowestFree = 2'h0;
      for (int i = dchp_pkg::NUM_DRV - 1; i >= 0; i--)
         if (ok[i]) lowestFree = 2'(i);
   endfunction

   wire isSeek    = (opcode == dchp_pkg::OPC_SEEK);
   wire isRecal   = (opcode == dchp_pkg::OPC_RECAL);
   wire isNoop    = (opcode == dchp_pkg::OPC_NOOP);
   wire isPosOp   = isSeek || isRecal;
   wire global_io_reset_instr     = hostReq.ioReset;
   wire doClear   = hostReq.fnClear || global_io_reset_instr;
   wire doStart   = hostReq.fnStart && !doClear;
   wire doPulse   = hostReq.fnPulse && !doClear && isPosOp;
   wire sscWrite  = hostReq.outC && !isSeek && !busy && !global_io_reset_instr;
   wire [5:0] newSurf = SURF_SIX ?
                      hostDataOut[dchp_pkg::SURF_HI:dchp_pkg::SURF_LO]
                    : {1'b0, hostDataOut[dchp_pkg::SURF5_HI:dchp_pkg::SURF_LO]};
   wire [4:0] newSect = hostDataOut[dchp_pkg::SECT_HI:dchp_pkg::SECT_LO];
   wire [4:0] newCnt  = hostDataOut[dchp_pkg::CNT_HI:dchp_pkg::CNT_LO];
   wire [3:0] freeDrv = readyS & ~reservedS;
   wire       illegal = (surfaceAddr > MAX_SURF) || (sectorAddr > MAX_SECT);
   wire       lastSect = (sectorAddr == MAX_SECT);
   wire [4:0] cntInc   = sectorCount + dchp_pkg::FLD_ONE;

   // ****************************************************
   // Transfer control
   // ****************************************************
   dchp_pkg::dchp_xfer_e state_r, state_nxt;
   logic retried_r, tmoFired, illFlag_r, eccFlag_r, badFlag_r, tmoFlag_r;
   logic [3:0] seekDone_r;
   logic recalPend_r;

   dchp_timeout #(.LIMIT(TMO_CYCLES)) uTmo (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .arm     (doStart),
      .run     (busy),
      .expired (tmoFired)
   );

   wire running   = (state_r == dchp_pkg::XS_RUN) && !doClear;
   wire chkFail   = (state_r == dchp_pkg::XS_CHECK) && illegal && !doClear;
   wire badHit    = running && badSectorMark;
   wire tmoHit    = running && tmoFired && !badHit;
   wire secOk     = running && sectorEnd && !eccMismatch && !badHit && !tmoHit;
   wire eccHit    = running && sectorEnd && eccMismatch && !badHit && !tmoHit;
   wire doRetry   = eccHit && retryEnable && !retried_r && (opcode == dchp_pkg::OPC_READ);
   wire eccFinal  = eccHit && !doRetry;
   wire advance   = secOk || eccFinal;
   wire lastDone  = secOk && (cntInc == dchp_pkg::FLD_ZERO);
   wire finish    = chkFail || badHit || tmoHit || eccFinal || lastDone;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dchp_pkg::XS_IDLE:  if (doStart && !isPosOp && !isNoop) state_nxt = dchp_pkg::XS_CHECK;
         dchp_pkg::XS_CHECK: state_nxt = illegal ? dchp_pkg::XS_IDLE : dchp_pkg::XS_RUN;
         dchp_pkg::XS_RUN:   if (finish) state_nxt = dchp_pkg::XS_IDLE;
         default:            state_nxt = dchp_pkg::XS_IDLE;
      endcase
      if (doClear) state_nxt = dchp_pkg::XS_IDLE;
   end

   // ****************************************************
   // State registers
   // ****************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r       <= dchp_pkg::XS_IDLE;
         busy          <= 1'b0;
         done          <= 1'b0;
         retried_r     <= 1'b0;
         seekEndPrev_r <= 4'h0;
      end else if (ce) begin
         state_r       <= state_nxt;
         seekEndPrev_r <= seekEndS;
         if (doClear) begin
            busy <= 1'b0;
            done <= 1'b0;
         end else if (doStart) begin
            busy <= 1'b1;
            done <= 1'b0;
         end else if (finish) begin
            busy <= 1'b0;
            done <= 1'b1;
         end
         if (doStart || advance)
            retried_r <= 1'b0;
         else if (doRetry)
            retried_r <= 1'b1;
      end
   end

   // ****************************************************
   // Address, count and opcode registers
   // ****************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         surfaceAddr <= dchp_pkg::SURF_ZERO;
         sectorAddr  <= dchp_pkg::FLD_ZERO;
         sectorCount <= dchp_pkg::FLD_ZERO;
         opcode      <= dchp_pkg::OPC_ZERO;
         driveSel    <= 2'h0;
      end else if (ce) begin
         if (global_io_reset_instr) begin
            surfaceAddr <= dchp_pkg::SURF_ZERO;
            sectorAddr  <= dchp_pkg::FLD_ZERO;
            sectorCount <= dchp_pkg::FLD_ZERO;
            opcode      <= dchp_pkg::OPC_ZERO;
            driveSel    <= 2'h0;
         end else if (sscWrite) begin
            surfaceAddr <= newSurf;
            sectorAddr  <= newSect;
            sectorCount <= newCnt;
         end else if (advance) begin
            // Bad sector and timeout leave the pointer on the failing sector
            sectorCount <= cntInc;
            sectorAddr  <= lastSect ? dchp_pkg::FLD_ZERO : sectorAddr + dchp_pkg::FLD_ONE;
            if (lastSect)
               surfaceAddr <= surfaceAddr + 6'h01;
         end
         if (hostReq.outA && !global_io_reset_instr && !busy) begin
            opcode   <= hostDataOut[dchp_pkg::OPC_HI:dchp_pkg::OPC_LO];
            driveSel <= hostDataOut[dchp_pkg::DSEL_HI:dchp_pkg::DSEL_LO];
         end
      end
   end

   // ****************************************************
   // Error and attention flags; a set beats a clear
   // ****************************************************
   wire clrErr = doClear || doStart;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         illFlag_r  <= 1'b0;
         eccFlag_r  <= 1'b0;
         badFlag_r  <= 1'b0;
         tmoFlag_r  <= 1'b0;
         seekDone_r <= 4'h0;
         ctrlFull   <= 1'b0;
      end else if (ce) begin
         illFlag_r  <= chkFail || (illFlag_r && !clrErr);
         eccFlag_r  <= eccHit || (eccFlag_r && !clrErr);
         badFlag_r  <= badHit || (badFlag_r && !clrErr);
         tmoFlag_r  <= tmoHit || (tmoFlag_r && !clrErr);
         seekDone_r <= seekEndRise | (seekDone_r & {4{!doClear}});
         ctrlFull   <= doPulse || (ctrlFull && !driveOrderTaken);
      end
   end

   // ****************************************************
   // Launches toward drive and transfer engine
   // ****************************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         xferCtl        <= '0;
         posLaunch      <= 1'b0;
         posOpcode      <= dchp_pkg::OPC_ZERO;
         posDrive       <= 2'h0;
         recalPend_r    <= 1'b0;
         attnIntDisable <= 1'b0;
         memAddrZero    <= 1'b0;
         altModesOff    <= 1'b0;
      end else if (ce) begin
         xferCtl.launch <= (state_r == dchp_pkg::XS_CHECK) && !illegal && !doClear;
         xferCtl.retry  <= doRetry;
         xferCtl.abort  <= doClear || badHit || tmoHit;
         xferCtl.opcode <= opcode;
         memAddrZero    <= global_io_reset_instr;
         altModesOff    <= global_io_reset_instr;
         recalPend_r    <= global_io_reset_instr;
         if (doStart)
            attnIntDisable <= 1'b1;
         else if (doClear)
            attnIntDisable <= 1'b0;
         // Recalibrate waits one cycle so clear actions land first
         posLaunch <= doPulse || (recalPend_r && (freeDrv != 4'h0));
         if (doPulse) begin
            posOpcode <= opcode;
            posDrive  <= driveSel;
         end else if (recalPend_r) begin
            posOpcode <= dchp_pkg::OPC_RECAL;
            posDrive  <= lowestFree(freeDrv);
         end
      end
   end

   // ****************************************************
   // Status word
   // ****************************************************
   logic [15:0] statusWord;
   wire errSum = illFlag_r || eccFlag_r || badFlag_r || tmoFlag_r || driveErrS;
   always_comb begin
      statusWord = 16'h0000;
      statusWord[15 - dchp_pkg::ST_FULL]    = ctrlFull;
      statusWord[15 - dchp_pkg::ST_DONE]    = done;
      for (int i = 0; i < dchp_pkg::NUM_DRV; i++)
         statusWord[15 - dchp_pkg::ST_SEEK0 - i] = seekDone_r[i];
      statusWord[15 - dchp_pkg::ST_ILLADR]  = illFlag_r;
      statusWord[15 - dchp_pkg::ST_ECC]     = eccFlag_r;
      statusWord[15 - dchp_pkg::ST_BADSECT] = badFlag_r;
      statusWord[15 - dchp_pkg::ST_TMO]     = tmoFlag_r;
      statusWord[15 - dchp_pkg::ST_ERR]     = errSum;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         hostDataIn <= 16'h0000;
      else if (ce && hostReq.inA)
         hostDataIn <= statusWord;
   end

endmodule

//--- dchp_host_io_port_props.sv
// Assertion checker for the disk controller host I/O port
`timescale 1ns/100ps
module dchp_host_io_port_props #(
   parameter bit         SURF_SIX = 1'b0,
   parameter logic [5:0] MAX_SURF = 6'h04,
   parameter logic [4:0] MAX_SECT = 5'h17
) (
   input wire logic                     sys_clk,
   input wire logic                     sys_rst,
   input wire logic                     ce,
   input wire dchp_pkg::dchp_host_req_s hostReq,
   input wire logic [15:0]              hostDataOut,
   input wire logic [15:0]              hostDataIn,
   input wire logic                     busy,
   input wire logic                     done,
   input wire logic                     ctrlFull,
   input wire logic                     sectorEnd,
   input wire logic                     eccMismatch,
   input wire logic                     badSectorMark,
   input wire dchp_pkg::dchp_xfer_ctl_s xferCtl,
   input wire logic [5:0]               surfaceAddr,
   input wire logic [4:0]               sectorAddr,
   input wire logic [4:0]               sectorCount,
   input wire logic [3:0]               opcode,
   input wire logic                     posLaunch,
   input wire logic [3:0]               posOpcode,
   input wire logic                     memAddrZero,
   input wire logic                     altModesOff
);
   // ************
   // Helpers
   // ************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Clear and reset win over start, pulse and the engine, so keep them out
   wire quiet   = ce && !hostReq.fnClear && !hostReq.ioReset;
   wire engIdle = !sectorEnd && !badSectorMark && !eccMismatch;
   wire readReq = quiet && engIdle && hostReq.fnStart && !busy
                  && opcode == dchp_pkg::OPC_READ;
   wire adrOk   = surfaceAddr <= MAX_SURF && sectorAddr <= MAX_SECT;
   // ************
   // Assertions
   // ************
   AST_START_BUSY: assert property (quiet && engIdle && hostReq.fnStart |=> busy && !done)
      else $error("start did not set busy and clear done");
   AST_START_LAUNCH: assert property (readReq && adrOk
      |=> !xferCtl.launch ##1 xferCtl.launch)
      else $error("read start did not launch on time");
   AST_ILLEGAL: assert property (readReq && !adrOk |=> ##1 done && !busy && !xferCtl.launch)
      else $error("bad address did not end the operation");
   AST_END_SAME: assert property ($rose(done) |-> !busy)
      else $error("done rose while busy stayed high");
   AST_CLEAR: assert property (ce && (hostReq.fnClear || hostReq.ioReset) && engIdle
      |=> !busy && !done)
      else $error("clear left busy or done set");
   AST_PULSE: assert property (quiet && hostReq.fnPulse
      && (opcode == dchp_pkg::OPC_SEEK || opcode == dchp_pkg::OPC_RECAL)
      |=> ctrlFull && posLaunch && posOpcode == $past(opcode))
      else $error("pulse did not launch positioning");
   AST_LOAD: assert property (quiet && hostReq.outC && !busy
      && opcode != dchp_pkg::OPC_SEEK
      |=> surfaceAddr == (SURF_SIX ? $past(hostDataOut[15:10])
                                   : {1'b0, $past(hostDataOut[14:10])})
      && {sectorAddr, sectorCount} == $past(hostDataOut[9:0]))
      else $error("address word not loaded");
   AST_HOLD: assert property (ce && !hostReq.ioReset && engIdle && hostReq.outC
      && (busy || opcode == dchp_pkg::OPC_SEEK)
      |=> $stable({surfaceAddr, sectorAddr, sectorCount}))
      else $error("refused address word changed registers");
   AST_STATUS: assert property (ce && hostReq.inA
      |=> hostDataIn[15] == $past(ctrlFull)
      && hostDataIn[14] == $past(done) && !hostDataIn[9])
      else $error("status word does not match flags");
   AST_GLOBAL_IO_RESET_INSTR: assert property (ce && hostReq.ioReset
      |=> memAddrZero && altModesOff
      && surfaceAddr == dchp_pkg::SURF_ZERO && sectorAddr == dchp_pkg::FLD_ZERO
      && opcode == dchp_pkg::OPC_ZERO)
      else $error("io reset did not zero registers");
   AST_BAD: assert property (ce && badSectorMark && busy && !hostReq.fnClear
      && !hostReq.ioReset |=> xferCtl.abort && done && !busy && $stable(sectorAddr))
      else $error("bad sector did not stop at once");
endmodule

bind dchp_host_io_port dchp_host_io_port_props #(
   .SURF_SIX(SURF_SIX), .MAX_SURF(MAX_SURF), .MAX_SECT(MAX_SECT)
) u_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .hostReq(hostReq),
   .hostDataOut(hostDataOut), .hostDataIn(hostDataIn), .busy(busy), .done(done),
   .ctrlFull(ctrlFull), .sectorEnd(sectorEnd), .eccMismatch(eccMismatch),
   .badSectorMark(badSectorMark), .xferCtl(xferCtl), .surfaceAddr(surfaceAddr),
   .sectorAddr(sectorAddr), .sectorCount(sectorCount), .opcode(opcode),
   .posLaunch(posLaunch), .posOpcode(posOpcode), .memAddrZero(memAddrZero),
   .altModesOff(altModesOff)
);

//--- dchp_pkg.sv
// Shared constants and types for the disk controller host I/O port
package dchp_pkg;

   // ****************************************************
   // Word layout, accumulator bit n is word bit 15-n
   // ****************************************************
   localparam int WORD_W     = 16;
   localparam int SURF_HI    = 15;
   localparam int SURF5_HI   = 14;
   localparam int SURF_LO    = 10;
   localparam int SECT_HI    = 9;
   localparam int SECT_LO    = 5;
   localparam int CNT_HI     = 4;
   localparam int CNT_LO     = 0;
   localparam int OPC_HI     = 10;
   localparam int OPC_LO     = 7;
   localparam int DSEL_HI    = 6;
   localparam int DSEL_LO    = 5;
   localparam int NUM_DRV    = 4;

   // ****************************************************
   // Status word positions (accumulator numbering)
   // ****************************************************
   localparam int ST_FULL    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_SEEK0   = 2;
   localparam int ST_ILLADR  = 7;
   localparam int ST_ECC     = 8;
   localparam int ST_BADSECT = 9;
   localparam int ST_TMO     = 13;
   localparam int ST_ERR     = 15;

   // ****************************************************
   // Opcodes and timing
   // ****************************************************
   localparam logic [3:0] OPC_NOOP  = 4'hB;
   localparam logic [3:0] OPC_SEEK  = 4'h2;
   localparam logic [3:0] OPC_RECAL = 4'h1;
   localparam logic [3:0] OPC_READ  = 4'h4;
   localparam logic [3:0] OPC_ZERO  = 4'h0;
   localparam logic [5:0] SURF_ZERO = 6'h00;
   localparam logic [4:0] FLD_ZERO  = 5'h00;
   localparam logic [4:0] FLD_ONE   = 5'h01;
   localparam longint CLK_HZ        = 100000000;
   localparam longint TMO_MS        = 1000;
   localparam longint TMO_CYC       = TMO_MS * CLK_HZ / 1000;

   // ****************************************************
   // Types
   // ****************************************************
   typedef struct packed {
      logic outA;
      logic outC;
      logic inA;
      logic fnStart;
      logic fnClear;
      logic fnPulse;
      logic ioReset;
   } dchp_host_req_s;

   typedef struct packed {
      logic launch;
      logic retry;
      logic abort;
      logic [3:0] opcode;
   } dchp_xfer_ctl_s;

   typedef enum logic [1:0] {XS_IDLE, XS_CHECK, XS_RUN} dchp_xfer_e;

endpackage

//--- dchp_sync.sv
// Two-flop synchroniser for drive-side level pins
`timescale 1ns/100ps
module dchp_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_r  <= '0;
         syncOut <= '0;
      end else if (ce) begin
         meta_r  <= asyncIn;
         syncOut <= meta_r;
      end
   end

endmodule

//--- dchp_timeout.sv
// Read/write timeout counter, expired stays high from the limit until run falls or arm
`timescale 1ns/100ps
module dchp_timeout #(
   parameter longint LIMIT = 100000000
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   input  wire logic arm,
   input  wire logic run,
   output logic      expired
);

   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   initial begin
      if (LIMIT < 2) $error("dchp_timeout: LIMIT too small");
   end

   logic [CW-1:0] count_r;
   wire           atLast = (count_r == LAST);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_r <= '0;
         expired <= 1'b0;
      end else if (ce) begin
         expired <= run && !arm && atLast;
         if (arm || !run)
            count_r <= '0;
         else if (!atLast)
            count_r <= count_r + CW'(1);
      end
   end

endmodule

//--- testbench.sv
// Self-checking testbench for the disk controller host I/O port
`timescale 1ns/100ps
module testbench;
   localparam logic [6:0] Q_OUTA  = 7'h40;
   localparam logic [6:0] Q_OUTC  = 7'h20;
   localparam logic [6:0] Q_INA   = 7'h10;
   localparam logic [6:0] Q_START = 7'h08;
   localparam logic [6:0] Q_CLEAR = 7'h04;
   localparam logic [6:0] Q_PULSE = 7'h02;
   localparam logic [6:0] Q_RESET = 7'h01;
   logic                     sys_clk = 1'b0;
   logic                     sys_rst = 1'b1;
   dchp_pkg::dchp_host_req_s req = '0;
   dchp_pkg::dchp_xfer_ctl_s xferCtl;
   logic [15:0]              dOut = 16'h0000;
   logic [15:0]              dIn;
   logic                     retryEn = 1'b0;
   logic                     sectEnd = 1'b0;
   logic                     eccErr = 1'b0;
   logic                     badMark = 1'b0;
   logic                     drvErr = 1'b0;
   logic                     busy, done, ctrlFull, posLaunch, orderTaken;
   logic                     attnIntDisable, memAddrZero, altModesOff;
   logic [5:0]               surfaceAddr;
   logic [4:0]               sectorAddr, sectorCount;
   logic [3:0]               opcode, posOpcode, seekEnd, ready, reserved;
   logic [1:0]               posDrive, driveSel;
   int                       err_count = 0;
   int                       cmp_count = 0;

   always #5 sys_clk = ~sys_clk;

   dchp_host_io_port #(.TMO_CYCLES(50)) dchp_host_io_port_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1), .hostReq(req),
      .hostDataOut(dOut), .hostDataIn(dIn), .busy(busy), .done(done),
      .ctrlFull(ctrlFull), .retryEnable(retryEn), .sectorEnd(sectEnd),
      .eccMismatch(eccErr), .badSectorMark(badMark), .xferCtl(xferCtl),
      .surfaceAddr(surfaceAddr), .sectorAddr(sectorAddr), .sectorCount(sectorCount),
      .opcode(opcode), .driveSel(driveSel), .posLaunch(posLaunch), .posOpcode(posOpcode),
      .posDrive(posDrive), .driveOrderTaken(orderTaken), .driveSeekEndPin(seekEnd),
      .driveReadyPin(ready), .driveReservedPin(reserved), .driveErrorPin(drvErr),
      .attnIntDisable(attnIntDisable), .memAddrZero(memAddrZero),
      .altModesOff(altModesOff)
   );

   dchp_drive_model dchp_drive_model_inst (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .posLaunch(posLaunch),
      .posDrive(posDrive), .driveOrderTaken(orderTaken), .driveSeekEndPin(seekEnd),
      .driveReadyPin(ready), .driveReservedPin(reserved)
   );

   // ************
   // Tasks
   // ************
   task tick;
      @(posedge sys_clk);
      #1;
   endtask
   // Strobe lives one edge; the leading tick keeps drives apart
   task hq(input logic [6:0] r);
      tick;
      req = dchp_pkg::dchp_host_req_s'(r);
      tick;
      req = '0;
   endtask
   task eng(input logic [2:0] v);
      tick;
      {sectEnd, eccErr, badMark} = v;
      tick;
      {sectEnd, eccErr, badMark} = 3'h0;
   endtask
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr_op(input logic [3:0] op, input logic [1:0] d);
      dOut = {5'h00, op, d, 5'h00};
      hq(Q_OUTA);
   endtask
   task wr_ssc(input logic [15:0] w);
      dOut = w;
      hq(Q_OUTC);
   endtask
   task rd_stat(input logic [15:0] e);
      hq(Q_INA);
      chk("status", e, dIn);
   endtask
   task tend(input string n);
      $display("Test %s finished", n);
   endtask
   task test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task wait_done(input int n);
      int i;
      for (i = 0; i < n && done !== 1'b1; i++) tick;
      cmp_count++;
      if (done !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED done expected 1 seen %b", done);
         test_done;
      end
   endtask

   // ************
   // Sequence
   // ************
   initial begin
      repeat (10) tick;
      sys_rst = 1'b0;
      rd_stat(16'h0000);
      tend("reset");
      wr_op(dchp_pkg::OPC_READ, 2'h0);
      wr_ssc({1'b0, 5'h03, 5'h05, 5'h1E});
      chk("surface", 16'h0003, {10'h000, surfaceAddr});
      chk("sector", 16'h0005, {11'h000, sectorAddr});
      chk("count", 16'h001E, {11'h000, sectorCount});
      hq(Q_START);
      chk("busy done", 16'h0002, {14'h0000, busy, done});
      tick;
      chk("launch", 16'h0013, {10'h000, xferCtl.opcode, xferCtl.launch, attnIntDisable});
      // Refusal case: full word while busy
      wr_ssc(16'h7FFF);
      chk("busy load", 16'h0005, {11'h000, sectorAddr});
      eng(3'h4);
      chk("advance", 16'h00DF, {6'h00, sectorAddr, sectorCount});
      eng(3'h4);
      wait_done(10);
      chk("end busy", 16'h0000, {15'h0000, busy});
      rd_stat(16'h4000);
      tend("transfer");
      wr_op(dchp_pkg::OPC_SEEK, 2'h1);
      wr_ssc(16'h0000);
      chk("seek load", 16'h0007, {11'h000, sectorAddr});
      hq(Q_PULSE);
      chk("pulse", 16'h00C9, {8'h00, ctrlFull, posLaunch, posOpcode, posDrive});
      rd_stat(16'hC000);
      repeat (25) tick;
      rd_stat(16'h5000);
      tend("seek");
      hq(Q_CLEAR);
      chk("clear", 16'h0000, {13'h0000, busy, done, attnIntDisable});
      rd_stat(16'h0000);
      tend("clear");
      wr_op(dchp_pkg::OPC_READ, 2'h3);
      wr_ssc({1'b0, 5'h05, 5'h00, 5'h1F});
      hq(Q_START);
      wait_done(5);
      chk("illegal", 16'h0000, {14'h0000, busy, xferCtl.launch});
      rd_stat(16'h4101);
      tend("illegal address");
      wr_ssc({1'b0, 5'h02, 5'h03, 5'h1E});
      hq(Q_START);
      tick;
      eng(3'h1);
      chk("bad", 16'h00C3, {8'h00, xferCtl.abort, done, busy, sectorAddr});
      rd_stat(16'h4041);
      tend("bad sector");
      retryEn = 1'b1;
      wr_ssc({1'b0, 5'h02, 5'h03, 5'h1F});
      hq(Q_START);
      tick;
      eng(3'h6);
      chk("retry", 16'h0001, {15'h0000, xferCtl.retry});
      eng(3'h6);
      wait_done(5);
      chk("ecc sector", 16'h0004, {11'h000, sectorAddr});
      rd_stat(16'h4081);
      tend("ecc");
      retryEn = 1'b0;
      wr_ssc({1'b0, 5'h01, 5'h01, 5'h1F});
      hq(Q_START);
      wait_done(80);
      rd_stat(16'h4005);
      tend("timeout");
      hq(Q_CLEAR);
      drvErr = 1'b1;
      repeat (3) tick;
      rd_stat(16'h0001);
      drvErr = 1'b0;
      tend("drive error");
      hq(Q_RESET);
      chk("rst pulses", 16'h0003, {14'h0000, memAddrZero, altModesOff});
      chk("rst regs", 16'h0000, {1'b0, surfaceAddr, sectorAddr, opcode});
      chk("rst drive", 16'h0000, {14'h0000, driveSel});
      tick;
      chk("recal", 16'h0046, {9'h000, posLaunch, posOpcode, posDrive});
      tend("io reset");
      test_done;
   end
endmodule
